// >>> logic/lbsp_device.sv
// device end: synchronous 32-bit slave on the local bus pins
`timescale 1ns/100ps
// Notes on behaviour
// R1: decode address bits 2-15, latched at strobe rise
// R2: accept only while I/O qualifier is low
// R3: sample direction at first clock with cycle
// R4: byte selects transparent, held from strobe rise
// R5: host delays address strobe one clock for cycle
// R6: all transfers timed on bus clock rises
// R7: host uses only allowed access widths
// R8: glue makes open-drain local ready from ready
// R9: ready return wired straight to device
// R10: host inverts bus reset into device reset
// R11: interrupt output routed to a host line
// R12: write touches only selected byte lanes
module lbsp_device import lbsp_pkg::*; #(
	parameter int NREG = NREG_DEF,
	parameter logic [ADDR_W-1:0] BASE = DEV_BASE_DEF
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// bus pins
	lbsp_if.dev BUS,
	// user side
	input wire logic IRQ_REQ,
	output logic [NREG*DATA_W-1:0] REG_IMAGE,
	output logic ACCESS_PULSE
);
	localparam int IW = $clog2(NREG);
	localparam int SW = 3 + 1 + 1 + 1 + LANES + ADDR_W + DATA_W + 1;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SW-1:0] pins;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic clk_s, as_n_s, cyc_n_s, wnr_s, qual_s, rret_n_s, drst_s;
	logic [LANES-1:0] be_n_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;

	assign pins = {BUS.host_bus_clock, BUS.addr_strobe_n,
		BUS.cycle_strobe_n, BUS.write_not_read, BUS.io_space_qualifier,
		BUS.ready_return_n, BUS.byte_lane_select_n, BUS.host_addr_bits,
		BUS.data_bus, BUS.dev_reset};

	always_ff @(posedge MCLK) begin
		sync1_r <= pins;
		sync2_r <= sync1_r;
	end

	assign {clk_s, as_n_s, cyc_n_s, wnr_s, qual_s, rret_n_s, be_n_s,
		addr_s, data_s, drst_s} = sync2_r;

	// host-driven reset acts like the local one
	logic rst;
	assign rst = RST | drst_s;

	// ----------------------------------------------------------------
	// bus clock edge finder
	// ----------------------------------------------------------------
	logic clk_d_r;
	logic rise;

	always_ff @(posedge MCLK) begin
		if (rst) begin
			// bus clock idles high in reset: no false rise after it
			clk_d_r <= 1'b1;
		end else begin
			clk_d_r <= clk_s;
		end
	end

	assign rise = clk_s & ~clk_d_r; // R6

	// ----------------------------------------------------------------
	// transparent latches on the address strobe
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] addr_hold_r;
	logic qual_hold_r;
	logic [LANES-1:0] be_hold_r;
	logic [ADDR_W-1:0] addr_eff;
	logic qual_eff;
	logic [LANES-1:0] be_eff;

	always_ff @(posedge MCLK) begin
		if (rst) begin
			addr_hold_r <= ADDR_RST;
			qual_hold_r <= 1'b1;
			be_hold_r <= LANES_OFF;
		end else if (!as_n_s) begin
			addr_hold_r <= addr_s; // R1
			qual_hold_r <= qual_s; // R2
			be_hold_r <= be_n_s; // R4
		end
	end

	assign addr_eff = as_n_s ? addr_hold_r : addr_s; // R1
	assign qual_eff = as_n_s ? qual_hold_r : qual_s; // R2
	assign be_eff = as_n_s ? be_hold_r : be_n_s; // R4

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic hit;
	logic [IW-1:0] idx;

	// upper address bits select this device, low bits pick the word
	assign hit = !qual_eff &&
		(addr_eff[ADDR_W-1:IW] == BASE[ADDR_W-1:IW]); // R1 R2
	assign idx = addr_eff[IW-1:0];

	// ----------------------------------------------------------------
	// transfer sequencer
	// ----------------------------------------------------------------
	lbsp_dev_st_e st_r;
	logic start;

	// only the first rise with cycle low opens a transfer
	assign start = (st_r == DV_IDLE) && rise && !cyc_n_s; // R3

	always_ff @(posedge MCLK) begin
		if (rst) begin
			st_r <= DV_IDLE;
		end else begin
			case (st_r)
				DV_IDLE: begin
					if (start) begin
						st_r <= hit ? DV_ACK : DV_DONE; // R2
					end
				end
				DV_ACK: begin
					if (rise && !rret_n_s) begin // R9
						st_r <= DV_DONE;
					end
				end
				DV_DONE: begin
					// unclaimed cycles are left for another slave
					if (cyc_n_s) begin
						st_r <= DV_IDLE;
					end
				end
				default: begin
					st_r <= DV_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] regs_r [NREG];

	always_ff @(posedge MCLK) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				regs_r[i] <= DATA_RST;
			end
		end else if (start && hit && wnr_s) begin // R3
			for (int l = 0; l < LANES; l++) begin
				if (!be_eff[l]) begin // R12
					regs_r[idx][l*LANE_W +: LANE_W] <=
						data_s[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_img
			assign REG_IMAGE[g*DATA_W +: DATA_W] = regs_r[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	logic srdy_n_r;
	logic [DATA_W-1:0] rdata_r;
	logic d_oe_n_r;
	logic irq_r;
	logic acc_r;

	always_ff @(posedge MCLK) begin
		if (rst) begin
			srdy_n_r <= 1'b1;
		end else if (start && hit) begin
			srdy_n_r <= 1'b0;
		end else if (st_r == DV_ACK && rise && !rret_n_s) begin
			srdy_n_r <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (rst) begin
			rdata_r <= DATA_RST;
			d_oe_n_r <= 1'b1;
		end else if (start && hit && !wnr_s) begin // R3
			rdata_r <= regs_r[idx];
			d_oe_n_r <= 1'b0;
		end else if (st_r != DV_ACK) begin
			d_oe_n_r <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (rst) begin
			irq_r <= 1'b0;
			acc_r <= 1'b0;
		end else begin
			irq_r <= IRQ_REQ;
			acc_r <= start && hit;
		end
	end

	assign BUS.sync_ready_out_n = srdy_n_r;
	assign BUS.data_d_o = rdata_r;
	assign BUS.data_d_oe_n = d_oe_n_r;
	assign BUS.irq_out = irq_r;
	assign ACCESS_PULSE = acc_r;
endmodule

// >>> logic/lbsp_pkg.sv
// shared constants and types for the local bus slave port
package lbsp_pkg;
	// ----------------------------------------------------------------
	// clocking
	// ----------------------------------------------------------------
	localparam int MCLK_PERIOD_NS = 4;
	localparam int BUS_CLK_PERIOD_NS = 96;
	localparam int BUS_CLK_DIV = BUS_CLK_PERIOD_NS / MCLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// bus layout
	// ----------------------------------------------------------------
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int NREG_DEF = 8;

	// ----------------------------------------------------------------
	// reset values and default device base
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] DEV_BASE_DEF = 14'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
	localparam logic [LANES-1:0] LANES_OFF = 4'hf;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

	// ----------------------------------------------------------------
	// state machines
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DV_IDLE = 3'b001,
		DV_ACK = 3'b010,
		DV_DONE = 3'b100
	} lbsp_dev_st_e;

	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_ADDR = 4'b0010,
		HS_CYC = 4'b0100,
		HS_RET = 4'b1000
	} lbsp_host_st_e;
endpackage

// >>> logic/lbsp_if.sv
// pin-level carrier between the host glue and the device port
`timescale 1ns/100ps
interface lbsp_if;
	import lbsp_pkg::*;
	logic host_bus_clock;
	logic addr_strobe_n;
	logic cycle_strobe_n;
	logic write_not_read;
	logic io_space_qualifier;
	logic [LANES-1:0] byte_lane_select_n;
	logic [ADDR_W-1:0] host_addr_bits;
	logic [DATA_W-1:0] data_h_o;
	logic data_h_oe_n;
	logic [DATA_W-1:0] data_d_o;
	logic data_d_oe_n;
	logic [DATA_W-1:0] data_bus;
	logic sync_ready_out_n;
	logic lrdy_o;
	logic lrdy_oe_n;
	logic bus_local_ready_n;
	logic ready_return_n;
	logic dev_reset;
	logic irq_out;

	// undriven lines float high through the bus pull-ups
	assign data_bus = !data_h_oe_n ? data_h_o :
		(!data_d_oe_n ? data_d_o : '1);
	assign bus_local_ready_n = lrdy_oe_n ? 1'b1 : lrdy_o;

	modport dev (
		input host_bus_clock, addr_strobe_n, cycle_strobe_n,
		input write_not_read, io_space_qualifier, byte_lane_select_n,
		input host_addr_bits, data_bus, ready_return_n, dev_reset,
		output data_d_o, data_d_oe_n, sync_ready_out_n, irq_out
	);
	modport host (
		output host_bus_clock, addr_strobe_n, cycle_strobe_n,
		output write_not_read, io_space_qualifier, byte_lane_select_n,
		output host_addr_bits, data_h_o, data_h_oe_n, lrdy_o, lrdy_oe_n,
		output ready_return_n, dev_reset,
		input data_bus, sync_ready_out_n, bus_local_ready_n, irq_out
	);
endinterface

// >>> logic/lbsp_host.sv
// host end: bus clock source, strobe sequencer and ready glue
`timescale 1ns/100ps
module lbsp_host import lbsp_pkg::*; #(
	parameter int DIV = BUS_CLK_DIV
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// bus pins
	lbsp_if.host BUS,
	// request
	input wire logic REQ,
	input wire logic WRITE,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [LANES-1:0] LANES_N,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic QUAL,
	// answer
	output logic BUSY,
	output logic DONE,
	output logic [DATA_W-1:0] RDATA,
	output logic IRQ
);
	localparam int HALF = DIV / 2;
	localparam int CW = $clog2(DIV);

	// ----------------------------------------------------------------
	// bus clock divider and reset
	// ----------------------------------------------------------------
	logic [CW-1:0] cnt_r;
	logic bclk_r;
	logic fall;
	logic bus_reset_n_r;

	assign fall = (cnt_r == CW'(HALF - 1));

	always_ff @(posedge MCLK) begin
		if (RST) begin
			cnt_r <= '0;
			bclk_r <= 1'b1;
		end else begin
			cnt_r <= (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
			if (cnt_r == CW'(DIV - 1)) begin
				bclk_r <= 1'b1;
			end else if (fall) begin
				bclk_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		bus_reset_n_r <= !RST;
	end

	assign BUS.host_bus_clock = bclk_r; // R6
	assign BUS.dev_reset = !bus_reset_n_r; // R10

	// ----------------------------------------------------------------
	// synchronisers for device-driven pins
	// ----------------------------------------------------------------
	localparam int SW = 2 + DATA_W;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic lrdy_n_s, irq_s;
	logic [DATA_W-1:0] data_s;

	always_ff @(posedge MCLK) begin
		sync1_r <= {BUS.bus_local_ready_n, BUS.irq_out, BUS.data_bus};
		sync2_r <= sync1_r;
	end

	assign {lrdy_n_s, irq_s, data_s} = sync2_r;
	assign IRQ = irq_s; // R11

	// open-drain local ready from the device's ready
	assign BUS.lrdy_o = 1'b0; // R8
	assign BUS.lrdy_oe_n = BUS.sync_ready_out_n; // R8

	// ----------------------------------------------------------------
	// request capture
	// ----------------------------------------------------------------
	lbsp_host_st_e st_r;
	logic pend_r;
	logic wr_r;
	logic qual_r;
	logic [ADDR_W-1:0] addr_r;
	logic [LANES-1:0] be_r;
	logic [DATA_W-1:0] wd_r;

	assign BUSY = pend_r || (st_r != HS_IDLE);

	always_ff @(posedge MCLK) begin
		if (RST) begin
			pend_r <= 1'b0;
			wr_r <= 1'b0;
			qual_r <= 1'b1;
			addr_r <= ADDR_RST;
			be_r <= LANES_OFF;
			wd_r <= DATA_RST;
		end else if (REQ && !BUSY) begin
			pend_r <= 1'b1;
			wr_r <= WRITE;
			qual_r <= QUAL;
			addr_r <= ADDR;
			be_r <= LANES_N;
			wd_r <= WDATA;
		end else if (fall && st_r == HS_IDLE) begin
			pend_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// strobe sequencer, moves on bus clock falls
	// ----------------------------------------------------------------
	logic as_n_r, cyc_n_r, rret_n_r, oe_n_r, done_r;
	logic [DATA_W-1:0] rdata_r;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			st_r <= HS_IDLE;
			as_n_r <= 1'b1;
			cyc_n_r <= 1'b1;
			rret_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			done_r <= 1'b0;
			rdata_r <= DATA_RST;
		end else begin
			done_r <= 1'b0;
			if (fall) begin
				case (st_r)
					HS_IDLE: begin
						if (pend_r) begin
							as_n_r <= 1'b0;
							oe_n_r <= !wr_r;
							st_r <= HS_ADDR;
						end
					end
					HS_ADDR: begin
						as_n_r <= 1'b1;
						cyc_n_r <= 1'b0; // R5
						st_r <= HS_CYC;
					end
					HS_CYC: begin
						// no timeout: an unclaimed address hangs here
						if (!lrdy_n_s) begin
							cyc_n_r <= 1'b1;
							rret_n_r <= 1'b0; // R9
							rdata_r <= data_s;
							done_r <= 1'b1;
							st_r <= HS_RET;
						end
					end
					HS_RET: begin
						rret_n_r <= 1'b1;
						oe_n_r <= 1'b1;
						st_r <= HS_IDLE;
					end
					default: begin
						st_r <= HS_IDLE;
					end
				endcase
			end
		end
	end

	assign BUS.addr_strobe_n = as_n_r;
	assign BUS.cycle_strobe_n = cyc_n_r;
	assign BUS.ready_return_n = rret_n_r;
	assign BUS.write_not_read = wr_r;
	assign BUS.io_space_qualifier = qual_r;
	assign BUS.host_addr_bits = addr_r;
	assign BUS.byte_lane_select_n = be_r; // R7
	assign BUS.data_h_o = wd_r;
	assign BUS.data_h_oe_n = oe_n_r;
	assign DONE = done_r;
	assign RDATA = rdata_r;
endmodule

// >>> sim/lbsp_monitor.sv
// pin protocol checker for the local bus slave port
`timescale 1ns/100ps
module lbsp_monitor import lbsp_pkg::*; (
	// clock and resets
	input wire logic MCLK,
	input wire logic RST,
	input wire logic dev_reset,
	// host pins
	input wire logic host_bus_clock,
	input wire logic addr_strobe_n,
	input wire logic cycle_strobe_n,
	input wire logic write_not_read,
	input wire logic io_space_qualifier,
	input wire logic [LANES-1:0] byte_lane_select_n,
	input wire logic [ADDR_W-1:0] host_addr_bits,
	input wire logic ready_return_n,
	// device and glue pins
	input wire logic data_d_oe_n,
	input wire logic sync_ready_out_n,
	input wire logic bus_local_ready_n
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST || dev_reset);
	// ----------
	// host side
	// ----------
	a_cycle_delay: assert property (
		$fell(cycle_strobe_n)
		|-> $rose(addr_strobe_n) && !$past(addr_strobe_n, BUS_CLK_DIV))
		else $error("cycle strobe not one bus clock after address");
	a_strobe_on_low: assert property (
		$changed(addr_strobe_n) || $changed(cycle_strobe_n)
		|-> !host_bus_clock)
		else $error("strobe moved while bus clock high");
	a_addr_held: assert property (
		!cycle_strobe_n && $past(!cycle_strobe_n)
		|-> $stable(host_addr_bits) && $stable(io_space_qualifier))
		else $error("address moved inside a cycle");
	a_lanes_held: assert property (
		!cycle_strobe_n && $past(!cycle_strobe_n)
		|-> $stable(byte_lane_select_n))
		else $error("byte selects moved inside a cycle");
	a_ret_after_ready: assert property (
		$fell(ready_return_n) |-> !sync_ready_out_n)
		else $error("ready return without ready");
	// ----------
	// device side
	// ----------
	a_ready_bound: assert property (
		$fell(cycle_strobe_n) && !io_space_qualifier
		&& host_addr_bits[ADDR_W-1:3] == '0
		|-> ##[1:40] !sync_ready_out_n)
		else $error("no ready for a decoded cycle");
	a_ready_release: assert property (
		$fell(ready_return_n) |-> ##[1:40] sync_ready_out_n)
		else $error("ready not released after return");
	a_read_drive: assert property (
		!sync_ready_out_n && $past(!sync_ready_out_n)
		|-> data_d_oe_n == write_not_read)
		else $error("data drive disagrees with direction");
	a_local_ready: assert property (
		bus_local_ready_n == sync_ready_out_n)
		else $error("local ready does not follow ready");
	a_reset_on: assert property (
		disable iff (1'b0) RST |=> dev_reset)
		else $error("device reset missing during host reset");
	a_reset_off: assert property (
		disable iff (1'b0) !RST |=> !dev_reset)
		else $error("device reset held after host reset");
	c_write: cover property (!sync_ready_out_n && write_not_read);
	c_read: cover property (!sync_ready_out_n && !write_not_read);
	c_foreign: cover property (!cycle_strobe_n && host_addr_bits[3]);
	c_qual_high: cover property (!cycle_strobe_n && io_space_qualifier);
endmodule

// >>> sim/test_local_bus_slave_port.sv
// self-checking bench: host and device ends joined by the pin carrier
`timescale 1ns/100ps
module test_local_bus_slave_port;
	import lbsp_pkg::*;
	localparam int NR = NREG_DEF;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic write = 1'b0;
	logic [ADDR_W-1:0] addr = ADDR_RST;
	logic [LANES-1:0] lanes_n = LANES_OFF;
	logic [DATA_W-1:0] wdata = DATA_RST;
	logic irq_req = 1'b0;
	logic qual = 1'b0;
	logic busy, done, irq, acc;
	logic [DATA_W-1:0] rdata;
	logic [NR*DATA_W-1:0] image;
	logic [DATA_W-1:0] model [NR];
	logic [3:0] lane_tab [7] = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7};
	int failures = 0;
	int n_tests = 0;
	int n_acc = 0;
	int exp_acc = 0;
	int seed = 80231;
	lbsp_if bus ();
	always #2 mclk = ~mclk;
	always @(posedge mclk) if (acc === 1'b1) n_acc <= n_acc + 1;
	lbsp_host i_lbsp_host (.MCLK(mclk), .RST(rst), .BUS(bus), .REQ(req),
		.WRITE(write), .ADDR(addr), .LANES_N(lanes_n), .WDATA(wdata),
		.QUAL(qual), .BUSY(busy), .DONE(done), .RDATA(rdata), .IRQ(irq));
	lbsp_device i_lbsp_device (.MCLK(mclk), .RST(rst), .BUS(bus),
		.IRQ_REQ(irq_req), .REG_IMAGE(image), .ACCESS_PULSE(acc));
	lbsp_monitor i_lbsp_monitor (.MCLK(mclk), .RST(rst),
		.dev_reset(bus.dev_reset), .host_bus_clock(bus.host_bus_clock),
		.addr_strobe_n(bus.addr_strobe_n),
		.cycle_strobe_n(bus.cycle_strobe_n),
		.write_not_read(bus.write_not_read),
		.io_space_qualifier(bus.io_space_qualifier),
		.byte_lane_select_n(bus.byte_lane_select_n),
		.host_addr_bits(bus.host_addr_bits),
		.ready_return_n(bus.ready_return_n), .data_d_oe_n(bus.data_d_oe_n),
		.sync_ready_out_n(bus.sync_ready_out_n),
		.bus_local_ready_n(bus.bus_local_ready_n));
	// ----------
	// shared tasks
	// ----------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen,
				exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < NR; i++) model[i] = DATA_RST;
		repeat (8) @(posedge mclk);
	endtask
	// foreign addresses get no answer, so hang waits, gives up and checks nothing was accepted and the word at a[2:0] kept its value
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d,
		input logic hang);
		int k;
		logic [DATA_W-1:0] m;
		@(posedge mclk);
		req <= 1'b1;
		write <= wr;
		addr <= a;
		lanes_n <= ln;
		wdata <= d;
		@(posedge mclk);
		req <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 400) begin
			@(negedge mclk);
			k++;
		end
		check({31'h0, done}, {31'h0, !hang}, "answer");
		if (!hang) exp_acc++;
		check(n_acc, exp_acc, "accepted count");
		if (hang) begin
			check(image[a[2:0]*32 +: 32], model[a[2:0]], "refused");
			return;
		end
		m = model[a[2:0]];
		for (int i = 0; i < LANES; i++) if (!ln[i]) m[i*8 +: 8] = d[i*8 +: 8];
		if (wr) model[a[2:0]] = m;
		else check(rdata, model[a[2:0]], "read data");
		while (busy !== 1'b0 && k < 800) begin
			@(negedge mclk);
			k++;
		end
		check(image[a[2:0]*32 +: 32], model[a[2:0]], "register");
	endtask
	// ----------
	// main sequence
	// ----------
	initial begin
		logic [31:0] r;
		do_reset();
		foreach (lane_tab[j]) begin
			r = $random(seed);
			xfer(1'b1, {11'h0, r[2:0]}, lane_tab[j], $random(seed), 1'b0);
			xfer(1'b0, {11'h0, r[2:0]}, 4'h0, DATA_RST, 1'b0);
		end
		$display("test lanes done");
		repeat (40) begin
			r = $random(seed);
			xfer(r[3], {11'h0, r[2:0]}, lane_tab[r[7:4] % 7], $random(seed),
				1'b0);
		end
		$display("test random done");
		r = $random(seed);
		r[3] = 1'b1;
		xfer(1'b1, r[ADDR_W-1:0], 4'h0, $random(seed), 1'b1);
		do_reset();
		for (int i = 0; i < NR; i++) begin
			check(image[i*32 +: 32], model[i], "after reset");
		end
		// qualifier high: local word, but the cycle must be ignored
		@(posedge mclk);
		qual <= 1'b1;
		xfer(1'b1, 14'h0002, 4'h0, $random(seed), 1'b1);
		do_reset();
		qual <= 1'b0;
		xfer(1'b1, 14'h0007, 4'h0, $random(seed), 1'b0);
		xfer(1'b0, 14'h0007, 4'h0, DATA_RST, 1'b0);
		$display("test foreign done");
		@(posedge mclk);
		irq_req <= 1'b1;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		check({31'h0, irq}, 32'h1, "irq set");
		@(posedge mclk);
		irq_req <= 1'b0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		check({31'h0, irq}, 32'h0, "irq clear");
		$display("test irq done");
		give_verdict();
	end
	// about 60 transfers of ~90 cycles each, far inside this span
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule
